// ===== verilog/pmg_module_gate.sv
// peripheral module power gating: disable registers and per-module gates
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pmg_module_gate
	import pmg_pkg::*;
#(
	parameter int WAKE_CYC = PMG_WAKE_CYC
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_b_in,
	input  wire logic [3:0]              addr_in,
	input  wire logic [7:0]              wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic      [7:0]              rdata_out,
	// peripheral side, one bit per module in index order
	output logic [PMG_NUM_MODS-1:0]      mod_clk_en_out,
	output logic [PMG_NUM_MODS-1:0]      mod_rst_b_out,
	output logic [PMG_NUM_MODS-1:0]      mod_ready_out,
	output logic [PMG_NUM_MODS-1:0]      pin_route_en_out,
	// per-module special function register gating
	input  wire logic [PMG_NUM_MODS-1:0] mod_sfr_wr_in,
	input  wire logic [PMG_NUM_MODS-1:0] mod_sfr_rd_in,
	output logic [PMG_NUM_MODS-1:0]      mod_sfr_wr_out,
	output logic [PMG_NUM_MODS-1:0]      mod_sfr_rd_out,
	output logic                         mem_data_ready_out
);

	initial begin
		if (WAKE_CYC < 1 || WAKE_CYC > 255)
			$error("WAKE_CYC out of range");
	end

	logic [7:0]              ctrl0_q;
	logic [7:0]              ctrl1_q;
	logic [7:0]              rdata_q;
	logic [7:0]              rdata_d;
	logic [PMG_NUM_MODS-1:0] dis_w;
	logic [PMG_NUM_MODS-1:0] clk_en_q;
	logic [PMG_NUM_MODS-1:0] rst_b_q;
	logic [PMG_NUM_MODS-1:0] ready_q;
	logic [PMG_NUM_MODS-1:0] route_q;
	logic [PMG_NUM_MODS-1:0] sfr_wr_q;
	logic [PMG_NUM_MODS-1:0] sfr_rd_q;
	logic [9:0]              mem_cnt_q;
	logic                    mem_rdy_q;

	wire sel0_w = (addr_in == PMG_OFS_CTRL0);
	wire sel1_w = (addr_in == PMG_OFS_CTRL1);
	wire wr0_w  = wr_in & sel0_w;
	wire wr1_w  = wr_in & sel1_w;

	assign dis_w[PMG_IDX_VREF]   = ctrl0_q[PMG_VOLTAGE_REF_BIT];
	assign dis_w[PMG_IDX_MEM]    = ctrl0_q[PMG_MEMORY_CTRL_BIT];
	assign dis_w[PMG_IDX_CLKREF] = ctrl0_q[PMG_CLOCK_REF_OUT_BIT];
	assign dis_w[PMG_IDX_IOC]    = ctrl0_q[PMG_CHANGE_IRQ_BIT];
	assign dis_w[PMG_IDX_OSC]    = ctrl1_q[PMG_OSCILLATOR_BIT];
	assign dis_w[PMG_IDX_TMRC]   = ctrl1_q[PMG_TIMER_C_BIT];
	assign dis_w[PMG_IDX_TMRB]   = ctrl1_q[PMG_TIMER_B_BIT];
	assign dis_w[PMG_IDX_TMRA]   = ctrl1_q[PMG_TIMER_A_BIT];
	assign dis_w[PMG_IDX_SYSTEM_CLOCK_NET] = ctrl0_q[PMG_SYS_CLOCK_GATE_BIT];

	always_comb begin
		rdata_d = PMG_READ_ZERO;
		if (rd_in && sel0_w)
			rdata_d = ctrl0_q & PMG_CTRL0_MASK;
		else if (rd_in && sel1_w)
			rdata_d = ctrl1_q & PMG_CTRL1_MASK;
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl0_q <= PMG_CTRL0_RST;
			ctrl1_q <= PMG_CTRL1_RST;
			rdata_q <= PMG_READ_ZERO;
		end else begin
			if (wr0_w)
				ctrl0_q <= wdata_in & PMG_CTRL0_MASK;
			if (wr1_w)
				ctrl1_q <= wdata_in & PMG_CTRL1_MASK;
			rdata_q <= rdata_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < PMG_NUM_MODS; g++) begin : g_mod
			logic [7:0] wake_q;
			always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					clk_en_q[g] <= 1'b1;
					rst_b_q[g]  <= 1'b1;
					ready_q[g]  <= 1'b1;
					route_q[g]  <= 1'b1;
					sfr_wr_q[g] <= 1'b0;
					sfr_rd_q[g] <= 1'b0;
					wake_q      <= 8'h00;
				end else begin
					clk_en_q[g] <= ~dis_w[g];
					rst_b_q[g]  <= ~dis_w[g];
					route_q[g]  <= ~dis_w[g];
					// writes dropped, reads blocked so data is zero
					sfr_wr_q[g] <= mod_sfr_wr_in[g] & ~dis_w[g];
					sfr_rd_q[g] <= mod_sfr_rd_in[g] & ~dis_w[g];
					// ready marks when software may touch it
					if (dis_w[g]) begin
						wake_q     <= 8'h00;
						ready_q[g] <= 1'b0;
					end else if (!ready_q[g]) begin
						wake_q <= wake_q + 8'h01;
						if (wake_q + 8'h01 >= 8'(WAKE_CYC))
							ready_q[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// memory data settle time after enable
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_cnt_q <= 10'h000;
			mem_rdy_q <= 1'b1;
		end else if (dis_w[PMG_IDX_MEM]) begin
			mem_cnt_q <= 10'h000;
			mem_rdy_q <= 1'b0;
		end else if (!mem_rdy_q) begin
			mem_cnt_q <= mem_cnt_q + 10'h001;
			if (mem_cnt_q + 10'h001 >= 10'(PMG_MEM_WAIT_CYC))
				mem_rdy_q <= 1'b1;
		end
	end

	assign rdata_out          = rdata_q;
	assign mod_clk_en_out     = clk_en_q;
	assign mod_rst_b_out      = rst_b_q;
	assign mod_ready_out      = ready_q;
	assign pin_route_en_out   = route_q;
	assign mod_sfr_wr_out     = sfr_wr_q;
	assign mod_sfr_rd_out     = sfr_rd_q;
	assign mem_data_ready_out = mem_rdy_q;

endmodule
`default_nettype wire

// ===== common/pmg_pkg.sv
// constants for the peripheral module power gating block
package pmg_pkg;
	localparam int          PMG_NUM_MODS    = 9;
	localparam logic [3:0]  PMG_OFS_CTRL0   = 4'h0;
	localparam logic [3:0]  PMG_OFS_CTRL1   = 4'h1;
	localparam logic [7:0]  PMG_CTRL0_RST   = 8'h00;
	localparam logic [7:0]  PMG_CTRL1_RST   = 8'h00;
	localparam logic [7:0]  PMG_CTRL0_MASK  = 8'hC7;
	localparam logic [7:0]  PMG_CTRL1_MASK  = 8'h87;
	// bit positions in control register zero
	localparam int          PMG_SYS_CLOCK_GATE_BIT  = 7;
	localparam int          PMG_VOLTAGE_REF_BIT     = 6;
	localparam int          PMG_MEMORY_CTRL_BIT     = 2;
	localparam int          PMG_CLOCK_REF_OUT_BIT   = 1;
	localparam int          PMG_CHANGE_IRQ_BIT      = 0;
	// bit positions in control register one
	localparam int          PMG_OSCILLATOR_BIT      = 7;
	localparam int          PMG_TIMER_C_BIT         = 2;
	localparam int          PMG_TIMER_B_BIT         = 1;
	localparam int          PMG_TIMER_A_BIT         = 0;
	// module index order on the peripheral side vectors
	localparam int          PMG_IDX_VREF    = 0;
	localparam int          PMG_IDX_MEM     = 1;
	localparam int          PMG_IDX_CLKREF  = 2;
	localparam int          PMG_IDX_IOC     = 3;
	localparam int          PMG_IDX_OSC     = 4;
	localparam int          PMG_IDX_TMRC    = 5;
	localparam int          PMG_IDX_TMRB    = 6;
	localparam int          PMG_IDX_TMRA    = 7;
	localparam int          PMG_IDX_SYSTEM_CLOCK_NET  = 8;
	localparam logic [7:0]  PMG_READ_ZERO   = 8'h00;
	// release delay: one instruction cycle at 8 MHz instruction rate
	localparam int          PMG_INSTR_NS    = 125;
	localparam int          PMG_CLK_NS      = 25;
	localparam int          PMG_WAKE_CYC    = (PMG_INSTR_NS + PMG_CLK_NS - 1) / PMG_CLK_NS;
	// memory data access settling time, 1 us
	localparam int          PMG_MEM_WAIT_NS = 1000;
	localparam int          PMG_MEM_WAIT_CYC = (PMG_MEM_WAIT_NS + PMG_CLK_NS - 1) / PMG_CLK_NS;
endpackage

// ===== bench/pmg_periph_model.sv
// gated peripherals counting their clock ticks
`timescale 1ns/1ps
`default_nettype none
module pmg_periph_model
	import pmg_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       sys_rst_b_in,
	input  wire logic [8:0] en_in,
	input  wire logic [8:0] mod_rst_b_in,
	output logic      [7:0] cnt_out [PMG_NUM_MODS]
);
	always_ff @(posedge clk_in or negedge sys_rst_b_in) begin
		for (int i = 0; i < PMG_NUM_MODS; i++) begin
			if (!sys_rst_b_in || !mod_rst_b_in[i]) begin
				cnt_out[i] <= 8'h00;
			end else if (en_in[i]) begin
				cnt_out[i] <= cnt_out[i] + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ===== bench/pmg_module_gate_chk.sv
// port assertions for the module gating block
`timescale 1ns/1ps
`default_nettype none
module pmg_module_gate_chk
	import pmg_pkg::*;
#(
	parameter int WAKE_CYC = 5
) (
	input wire logic       sys_clk_in,
	input wire logic       rst_b_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic [8:0] mod_clk_en_out,
	input wire logic [8:0] mod_rst_b_out,
	input wire logic [8:0] mod_ready_out,
	input wire logic [8:0] pin_route_en_out,
	input wire logic [8:0] mod_sfr_wr_in,
	input wire logic [8:0] mod_sfr_wr_out,
	input wire logic       mem_data_ready_out
);
	localparam int WK = WAKE_CYC + 3;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_wr0(int b); wr_in && addr_in == 4'h0 && wdata_in[b]; endsequence
	property p_rst; $rose(rst_b_in) |-> rdata_out == 8'h00 && &mod_clk_en_out; endproperty
	property p_unmap; rd_in && addr_in > 4'h1 |=> rdata_out == 8'h00; endproperty
	property p_hold; mod_rst_b_out == mod_clk_en_out; endproperty
	property p_route; pin_route_en_out == mod_clk_en_out; endproperty
	property p_vref; s_wr0(6) |=> ##1 !mod_clk_en_out[PMG_IDX_VREF]; endproperty
	property p_sys; s_wr0(7) |=> ##1 !mod_clk_en_out[PMG_IDX_SYSTEM_CLOCK_NET]; endproperty
	property p_sfr; (mod_sfr_wr_out & ~($past(mod_sfr_wr_in)
		& (mod_clk_en_out | $past(mod_clk_en_out)))) == 9'h000; endproperty
	property p_wake; |(mod_clk_en_out & ~$past(mod_clk_en_out)) |->
		mod_ready_out != mod_clk_en_out ##[1:WK] mod_ready_out == mod_clk_en_out; endproperty
	property p_mem; $rose(mod_clk_en_out[PMG_IDX_MEM]) |->
		!mem_data_ready_out ##[1:48] mem_data_ready_out; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_hold: assert property (p_hold) else $error("reset gate differs");
	a_route: assert property (p_route) else $error("routing gate differs");
	a_vref: assert property (p_vref) else $error("disable bit ignored");
	a_sys: assert property (p_sys) else $error("system clock not gated");
	a_sfr: assert property (p_sfr) else $error("write reached disabled module");
	a_wake: assert property (p_wake) else $error("ready timing wrong");
	a_mem: assert property (p_mem) else $error("memory ready timing wrong");
endmodule
bind pmg_module_gate pmg_module_gate_chk #(.WAKE_CYC(WAKE_CYC)) pmg_module_gate_chk_i (.*);
`default_nettype wire

// ===== bench/tb_pmg_module_gate.sv
// self-checking bench for the module gating block
`timescale 1ns/1ps
`default_nettype none
module tb_pmg_module_gate;
	import pmg_pkg::*;
	logic sys_clk_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0, mrdy;
	logic [3:0] addr_in = 4'h0, a;
	logic [7:0] wdata_in = 8'h00, rdata_out, d, c0 = 8'h00, c1 = 8'h00, cnt [PMG_NUM_MODS];
	logic [8:0] en, clk_en, rst_b, rdy, route, swr, srd, swr_in = 9'h000, srd_in = 9'h000;
	int failures = 0, cmp_count = 0;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
	pmg_module_gate pmg_module_gate_i (.sys_clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .mod_clk_en_out(clk_en), .mod_rst_b_out(rst_b), .mod_ready_out(rdy),
		.pin_route_en_out(route), .mod_sfr_wr_in(swr_in), .mod_sfr_rd_in(srd_in),
		.mod_sfr_wr_out(swr), .mod_sfr_rd_out(srd), .mem_data_ready_out(mrdy));
	pmg_periph_model pmg_periph_model_i (.clk_in(sys_clk_in), .sys_rst_b_in(rst_b_in),
		.en_in(clk_en), .mod_rst_b_in(rst_b), .cnt_out(cnt));
	always #12.5 sys_clk_in = ~sys_clk_in;
	task automatic cyc(int n); repeat (n) @(posedge sys_clk_in); endtask
	task automatic wr(logic [3:0] ad, logic [7:0] dt);
		wr_in <= 1'b1; addr_in <= ad; wdata_in <= dt; cyc(1); wr_in <= 1'b0;
	endtask
	task automatic rd(logic [3:0] ad, logic [7:0] e);
		rd_in <= 1'b1; addr_in <= ad; cyc(1); rd_in <= 1'b0;
		#1 `CHK("rdata", e, rdata_out)
		// realign so the next strobe starts right after an edge
		cyc(1);
	endtask
	task automatic end_sim;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(59325));
		cyc(3); rst_b_in <= 1'b1; cyc(1);
		#1 `CHK("reset", 9'h1ff, clk_en & rst_b & route)
		cyc(1);
		for (int k = 0; k < 27; k++) begin
			a = 4'(k % 3);
			d = 8'($urandom) | (8'h01 << (k / 3));
			wr(a, d);
			if (a == 4'h0) c0 = d & PMG_CTRL0_MASK; else if (a == 4'h1) c1 = d & PMG_CTRL1_MASK;
			en = ~{c0[7], c1[0], c1[1], c1[2], c1[7], c0[0], c0[1], c0[2], c0[6]};
			cyc(2);
			`CHK("gate", {en, en, en}, {clk_en, rst_b, route})
			rd(4'h0, c0); rd(4'h1, c1); rd(4'h2, 8'h00);
			cyc(50);
			`CHK("ready", {en, en[1]}, {rdy, mrdy})
			for (int i = 0; i < PMG_NUM_MODS; i++) if (!en[i]) `CHK("cnt", 8'h00, cnt[i])
			swr_in <= 9'h1ff; srd_in <= 9'h1ff; cyc(1); swr_in <= 9'h000; srd_in <= 9'h000;
			#1 `CHK("sfr", {en, en}, {swr, srd})
			cyc(1);
		end
		end_sim();
	end
endmodule
`default_nettype wire
